// ===== rtl/smp_provisioning.sv
`timescale 1ns/1ps
`include "smp_defines.svh"

// Overview of operation
// - Reset by low reset input or writing global soft-reset bit.
// - Broadcast bit set: each management write lands in both channels.
// - Receive deserialize and transmit serialize select: zero picks two-lane ratio.
// - Lane-mode bits one select single-lane pass-through on receive and transmit.
// - Reference select bit (pin low): zero picks input zero, one picks input one; pin high forces input one.
// - Fast PLL multiplier and fast receive/transmit rate fields drive the fast side.
// - Slow PLL multiplier and slow input/output rate fields drive the slow side.
// - Slow and fast PLL lock flags appear in health bits 1 and 0.
// - Writing path-reset bit resets that channel's datapath.
// - Reading the health register clears its latched bits for that channel.
// - Health bits report follower, signal loss, autozero, gain, sync, code error.
// - Health bits 7:4 report FIFO underflow and overflow, zero when clean.
// - Health bits 3 and 2 report receive and transmit slow side good.
// - Receive two-lane mode: only slow lanes 0 and 1 carry data.
// - Receive pass-through mode: only slow lane 0 active.
module smp_provisioning (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic [4:0] port_address,
  input wire logic chan_a_powerdown_n,
  input wire logic chan_b_powerdown_n,
  input wire logic pattern_gen_enable_pin,
  input wire logic chan_a_refclk_pin_select,
  input wire logic chan_b_refclk_pin_select,
  input wire smp_pkg::smp_word_t chan_a_health_raw,
  input wire smp_pkg::smp_word_t chan_b_health_raw,
  output logic core_reset_active,
  output logic [1:0] pattern_gen_run,
  output logic [1:0] rx_deser_ratio_select,
  output logic [1:0] tx_ser_ratio_select,
  output logic [1:0] rx_lane_pass_through,
  output logic [1:0] tx_lane_pass_through,
  output logic [1:0] ref_input_select,
  output logic [1:0][3:0] fast_pll_multiplier,
  output logic [1:0][1:0] fast_rx_rate,
  output logic [1:0][1:0] fast_tx_rate,
  output logic [1:0] fast_receive_enable,
  output logic [1:0] fast_peaking_off,
  output logic [1:0][3:0] slow_pll_multiplier,
  output logic [1:0][1:0] slow_input_rate,
  output logic [1:0][1:0] slow_output_rate,
  output logic [1:0][3:0] lane_enable,
  output logic [1:0] lane_path_reset
);
  import smp_pkg::*;

  localparam logic [8:0] RESET_HOLD = 9'(`SMP_RESET_HOLD_CYC);

  smp_mgmt_if mgmt ();
  logic bcast_reg;
  logic [8:0] hold_cnt_reg;
  logic soft_reset;
  logic cfg_reset;
  logic [1:0] powered;
  logic [1:0] ref_pin;
  smp_word_t raw_in [2];

  // ----------------------------------------
  // Management frame engine
  // ----------------------------------------
  smp_mdio_slave u_mdio (
    .clk(clk),
    .reset_n(reset_n),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .port_address(port_address),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .mgmt(mgmt)
  );

  // ----------------------------------------
  // Global control and reset
  // ----------------------------------------
  // Soft reset is a self-clearing write bit, never stored
  assign soft_reset = mgmt.wr_strobe && mgmt.regad == `SMP_REG_GLOBAL
    && mgmt.wdata[`SMP_BIT_SOFT_RST];
  assign cfg_reset = !reset_n || soft_reset;

  // Broadcast flag
  always_ff @(posedge clk) begin
    if (cfg_reset) begin
      bcast_reg <= 1'b0;
    end else if (mgmt.wr_strobe && mgmt.regad == `SMP_REG_GLOBAL) begin
      bcast_reg <= mgmt.wdata[`SMP_BIT_BCAST];
    end
  end

  // Core reset held for the minimum reset time after either reset
  always_ff @(posedge clk) begin
    if (cfg_reset) begin
      hold_cnt_reg <= RESET_HOLD;
    end else if (hold_cnt_reg != 9'h000) begin
      hold_cnt_reg <= hold_cnt_reg - 9'h001;
    end
  end
  assign core_reset_active = hold_cnt_reg != 9'h000;

  // Pin groups per channel
  assign powered = {chan_b_powerdown_n, chan_a_powerdown_n};
  assign ref_pin = {chan_b_refclk_pin_select, chan_a_refclk_pin_select};
  assign raw_in[0] = chan_a_health_raw;
  assign raw_in[1] = chan_b_health_raw;

  // ----------------------------------------
  // Per-channel register banks
  // ----------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_chan
    smp_word_t mode_reg;
    smp_word_t fast1_reg;
    smp_word_t fast2_reg;
    smp_word_t slow1_reg;
    smp_word_t slow2_reg;
    smp_word_t overlay_reg;
    smp_word_t health;
    smp_word_t raw_gated;
    smp_word_t rd_word;
    logic hit;
    logic rd_clear;
    logic path_rst_reg;
    logic ref_sel_reg;
    logic pattern_reg;
    logic [3:0] lanes_reg;

    // Write reaches this channel when addressed or broadcast
    assign hit = mgmt.wr_strobe && (bcast_reg || mgmt.chan == 1'(c));
    assign rd_clear = mgmt.rd_strobe && mgmt.chan == 1'(c)
      && mgmt.regad == `SMP_REG_HEALTH;

    // Configuration registers
    always_ff @(posedge clk) begin
      if (cfg_reset) begin
        mode_reg <= `SMP_RST_MODE;
        fast1_reg <= `SMP_RST_FAST_CTL1;
        fast2_reg <= `SMP_RST_FAST_CTL2;
        slow1_reg <= `SMP_RST_SLOW_CTL1;
        slow2_reg <= `SMP_RST_SLOW_CTL2;
        overlay_reg <= `SMP_RST_OVERLAY;
      end else if (hit) begin
        unique case (mgmt.regad)
          `SMP_REG_MODE: mode_reg <= mgmt.wdata;
          `SMP_REG_FAST_CTL1: fast1_reg <= mgmt.wdata;
          `SMP_REG_FAST_CTL2: fast2_reg <= mgmt.wdata;
          `SMP_REG_SLOW_CTL1: slow1_reg <= mgmt.wdata;
          `SMP_REG_SLOW_CTL2: slow2_reg <= mgmt.wdata;
          `SMP_REG_OVERLAY: overlay_reg <= mgmt.wdata;
          default: ;
        endcase
      end
    end

    // Lane_path_reset pulse, self-clearing
    always_ff @(posedge clk) begin
      path_rst_reg <= !cfg_reset && hit && mgmt.regad == `SMP_REG_PATH_RST
        && mgmt.wdata[`SMP_BIT_PATH_RST];
    end

    // Registered derived controls: reference choice, lanes, pattern run
    always_ff @(posedge clk) begin
      if (cfg_reset) begin
        ref_sel_reg <= 1'b0;
        lanes_reg <= `SMP_LANES_QUAD;
        pattern_reg <= 1'b0;
      end else begin
        // Pin low hands the choice to software
        ref_sel_reg <= ref_pin[c] | mode_reg[`SMP_BIT_REF_SEL];
        pattern_reg <= pattern_gen_enable_pin & powered[c];
        if (mode_reg[`SMP_BIT_RX_LANE_MODE]) begin
          lanes_reg <= `SMP_LANES_SINGLE;
        end else if (!mode_reg[`SMP_BIT_RX_DESER]) begin
          lanes_reg <= `SMP_LANES_DUAL;
        end else begin
          lanes_reg <= `SMP_LANES_QUAD;
        end
      end
    end

    // Powered-down channel reports no lock and no good lanes
    assign raw_gated = powered[c] ? raw_in[c] : raw_in[c] & ~`SMP_HEALTH_LATCH_LOW;

    smp_chan_status u_status (
      .clk(clk),
      .reset_n(reset_n && !soft_reset),
      .clear(rd_clear),
      .raw(raw_gated),
      .health(health)
    );

    // Read data for this channel
    always_comb begin
      rd_word = '0;
      unique case (mgmt.regad)
        `SMP_REG_GLOBAL: rd_word[`SMP_BIT_BCAST] = bcast_reg;
        `SMP_REG_MODE: rd_word = mode_reg;
        `SMP_REG_FAST_CTL1: rd_word = fast1_reg;
        `SMP_REG_FAST_CTL2: rd_word = fast2_reg;
        `SMP_REG_SLOW_CTL1: rd_word = slow1_reg;
        `SMP_REG_SLOW_CTL2: rd_word = slow2_reg;
        `SMP_REG_OVERLAY: rd_word = overlay_reg;
        `SMP_REG_HEALTH: rd_word = health;
        default: rd_word = '0;
      endcase
    end

    // Channel outputs straight from registers
    assign rx_deser_ratio_select[c] = mode_reg[`SMP_BIT_RX_DESER];
    assign tx_ser_ratio_select[c] = mode_reg[`SMP_BIT_TX_SER];
    assign rx_lane_pass_through[c] = mode_reg[`SMP_BIT_RX_LANE_MODE];
    assign tx_lane_pass_through[c] = mode_reg[`SMP_BIT_TX_LANE_MODE];
    assign ref_input_select[c] = ref_sel_reg;
    assign fast_pll_multiplier[c] = fast1_reg[`SMP_FLD_MULT];
    assign fast_rx_rate[c] = fast2_reg[`SMP_FLD_RATE_HI];
    assign fast_tx_rate[c] = fast2_reg[`SMP_FLD_RATE_LO];
    assign fast_receive_enable[c] = fast2_reg[`SMP_BIT_FAST_ENRX];
    assign fast_peaking_off[c] = overlay_reg[`SMP_BIT_PEAK_OFF];
    assign slow_pll_multiplier[c] = slow1_reg[`SMP_FLD_MULT];
    assign slow_input_rate[c] = slow2_reg[`SMP_FLD_RATE_HI];
    assign slow_output_rate[c] = slow2_reg[`SMP_FLD_RATE_LO];
    assign lane_enable[c] = lanes_reg;
    assign lane_path_reset[c] = path_rst_reg;
    assign pattern_gen_run[c] = pattern_reg;
  end

  // Read data follows the addressed channel
  assign mgmt.rdata = mgmt.chan ? g_chan[1].rd_word : g_chan[0].rd_word;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  bcast_both_a: assert property (
    mgmt.wr_strobe && bcast_reg && mgmt.regad == `SMP_REG_MODE && !soft_reset
    |=> g_chan[0].mode_reg == $past(mgmt.wdata) && g_chan[1].mode_reg == $past(mgmt.wdata))
    else $error("broadcast write missed a channel");
  single_chan_a: assert property (
    mgmt.wr_strobe && !bcast_reg && mgmt.chan && !soft_reset
    |=> $stable(g_chan[0].mode_reg) && $stable(g_chan[0].fast1_reg))
    else $error("write leaked into other channel");
  deser_sel_a: assert property (
    mgmt.wr_strobe && !soft_reset && mgmt.regad == `SMP_REG_MODE && (bcast_reg || !mgmt.chan)
    |=> rx_deser_ratio_select[0] == $past(mgmt.wdata[9])
        && tx_ser_ratio_select[0] == $past(mgmt.wdata[8]))
    else $error("ratio select does not follow write");
  lane_map_a: assert property (
    g_chan[0].mode_reg[13:12] == 2'b00 && !g_chan[0].mode_reg[9] && !cfg_reset
    |=> lane_enable[0] == 4'h3)
    else $error("two-lane mode lane map wrong");
  pass_lane_a: assert property (
    rx_lane_pass_through[1] && !soft_reset |=> lane_enable[1] == 4'h1)
    else $error("pass-through lane map wrong");
  ref_choice_a: assert property (
    !chan_a_refclk_pin_select && !soft_reset |=> ref_input_select[0] == $past(g_chan[0].mode_reg[1]))
    else $error("reference choice not software driven");
  fast_mult_a: assert property (
    mgmt.wr_strobe && !soft_reset && mgmt.regad == `SMP_REG_FAST_CTL1 && (bcast_reg || !mgmt.chan)
    |=> fast_pll_multiplier[0] == $past(mgmt.wdata[3:0]))
    else $error("fast multiplier not updated");
  slow_rate_a: assert property (
    mgmt.wr_strobe && !soft_reset && mgmt.regad == `SMP_REG_SLOW_CTL2 && (bcast_reg || mgmt.chan)
    |=> slow_input_rate[1] == $past(mgmt.wdata[9:8]) && slow_output_rate[1] == $past(mgmt.wdata[1:0]))
    else $error("slow rate not updated");
  soft_reset_a: assert property (
    soft_reset |=> !bcast_reg && g_chan[0].fast2_reg == 16'hA444 && core_reset_active [*8])
    else $error("soft reset incomplete");
  path_pulse_a: assert property (
    mgmt.wr_strobe && !soft_reset && mgmt.regad == `SMP_REG_PATH_RST && mgmt.wdata[3] && bcast_reg
    |=> lane_path_reset == 2'b11 ##1 lane_path_reset == 2'b00)
    else $error("lane_path_reset pulse wrong");
  lock_off_a: assert property (
    !chan_b_powerdown_n [*2] |=> g_chan[1].health[1:0] == 2'b00)
    else $error("powered-down channel reports lock");
  // Lane map and enables follow the written mode and rate words
  quad_map_a: assert property (
    g_chan[1].mode_reg[9] && !g_chan[1].mode_reg[13] && !cfg_reset
    |=> lane_enable[1] == 4'hF)
    else $error("four-lane map wrong");
  tx_pass_a: assert property (
    mgmt.wr_strobe && !soft_reset && mgmt.regad == `SMP_REG_MODE && (bcast_reg || mgmt.chan)
    |=> tx_lane_pass_through[1] == $past(mgmt.wdata[12]))
    else $error("transmit lane mode does not follow write");
  enrx_follow_a: assert property (
    mgmt.wr_strobe && !soft_reset && mgmt.regad == `SMP_REG_FAST_CTL2 && (bcast_reg || !mgmt.chan)
    |=> fast_receive_enable[0] == $past(mgmt.wdata[2]))
    else $error("receive enable does not follow write");

  bcast_cover_c: cover property (mgmt.wr_strobe && bcast_reg);
  health_read_c: cover property (g_chan[0].rd_clear && g_chan[0].health[1:0] == 2'b11);
  path_reset_c: cover property (lane_path_reset[1]);
  quad_lanes_c: cover property (lane_enable == 8'hFF);
  soft_reset_c: cover property (soft_reset ##1 core_reset_active);
endmodule // smp_provisioning

// ===== rtl/smp_defines.svh
`ifndef SMP_DEFINES_SVH
`define SMP_DEFINES_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define SMP_REG_GLOBAL 5'h00
`define SMP_REG_MODE 5'h01
`define SMP_REG_FAST_CTL1 5'h02
`define SMP_REG_FAST_CTL2 5'h03
`define SMP_REG_SLOW_CTL1 5'h06
`define SMP_REG_SLOW_CTL2 5'h07
`define SMP_REG_OVERLAY 5'h09
`define SMP_REG_PATH_RST 5'h0E
`define SMP_REG_HEALTH 5'h0F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMP_BIT_SOFT_RST 15
`define SMP_BIT_BCAST 11
`define SMP_BIT_RX_LANE_MODE 13
`define SMP_BIT_TX_LANE_MODE 12
`define SMP_BIT_RX_DESER 9
`define SMP_BIT_TX_SER 8
`define SMP_BIT_REF_SEL 1
`define SMP_BIT_FAST_ENRX 2
`define SMP_BIT_PEAK_OFF 9
`define SMP_BIT_PATH_RST 3
`define SMP_FLD_MULT 3:0
`define SMP_FLD_RATE_HI 9:8
`define SMP_FLD_RATE_LO 1:0

// ----------------------------------------
// Health bit groups
// ----------------------------------------
`define SMP_HEALTH_LATCH_LOW 16'h5C0F
`define SMP_HEALTH_LATCH_HIGH 16'h21F0

// ----------------------------------------
// Reset values and lane maps
// ----------------------------------------
`define SMP_RST_MODE 16'h0000
`define SMP_RST_FAST_CTL1 16'h8115
`define SMP_RST_FAST_CTL2 16'hA444
`define SMP_RST_SLOW_CTL1 16'hF115
`define SMP_RST_SLOW_CTL2 16'hDC04
`define SMP_RST_OVERLAY 16'h0900
`define SMP_LANES_QUAD 4'hF
`define SMP_LANES_DUAL 4'h3
`define SMP_LANES_SINGLE 4'h1

// ----------------------------------------
// Timing and framing
// ----------------------------------------
`define SMP_CLK_PERIOD_PS 25000
`define SMP_RESET_MIN_US 10
`define SMP_RESET_HOLD_CYC \
  ((`SMP_RESET_MIN_US * 1000000 + `SMP_CLK_PERIOD_PS - 1) / `SMP_CLK_PERIOD_PS)
`define SMP_PREAMBLE_BITS 6'd32
`define SMP_HDR_LAST 6'd12
`define SMP_DATA_LAST 6'd15
`define SMP_DATA_BITS 6'd16

`endif

// ===== rtl/smp_pkg.sv
package smp_pkg;
  typedef logic [15:0] smp_word_t;
  typedef enum logic [2:0] {
    MD_PREAMBLE, MD_HEADER, MD_TURN, MD_WDATA, MD_RDATA
  } smp_mdio_state_t;
endpackage

// ===== rtl/smp_mgmt_if.sv
`timescale 1ns/1ps
interface smp_mgmt_if;
  import smp_pkg::*;
  logic wr_strobe;
  logic rd_strobe;
  logic chan;
  logic [4:0] regad;
  smp_word_t wdata;
  smp_word_t rdata;
  modport engine (output wr_strobe, rd_strobe, chan, regad, wdata, input rdata);
  modport regs (input wr_strobe, rd_strobe, chan, regad, wdata, output rdata);
endinterface

// ===== rtl/smp_mdio_slave.sv
`timescale 1ns/1ps
`include "smp_defines.svh"
module smp_mdio_slave (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mdc,
  input wire logic mdio_i,
  input wire logic [4:0] port_address,
  output logic mdio_o,
  output logic mdio_oe,
  smp_mgmt_if.engine mgmt
);
  import smp_pkg::*;
  smp_mdio_state_t state_reg;
  logic mdc_prev_reg;
  logic [5:0] cnt_reg;
  logic [15:0] shift_reg;
  logic is_read_reg;
  logic rise;
  logic [12:0] hdr;
  logic hdr_ok;

  // Edge of the management clock and header as it completes
  assign rise = mdc & ~mdc_prev_reg;
  assign hdr = {shift_reg[11:0], mdio_i};
  assign hdr_ok = hdr[12] & (hdr[11] ^ hdr[10]) & (hdr[9:6] == port_address[4:1]);

  always_ff @(posedge clk) begin
    mdc_prev_reg <= reset_n ? mdc : 1'b0;
  end

  // Frame engine: preamble, header, turnaround, data
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= MD_PREAMBLE;
      cnt_reg <= '0;
      shift_reg <= '0;
      is_read_reg <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
      mgmt.wr_strobe <= 1'b0;
      mgmt.rd_strobe <= 1'b0;
      mgmt.chan <= 1'b0;
      mgmt.regad <= '0;
      mgmt.wdata <= '0;
    end else begin
      mgmt.wr_strobe <= 1'b0;
      mgmt.rd_strobe <= 1'b0;
      if (mgmt.rd_strobe) begin
        shift_reg <= mgmt.rdata; // Captured before the clear takes hold
      end
      if (rise) begin
        unique case (state_reg)
          MD_PREAMBLE: begin
            if (mdio_i) begin
              cnt_reg <= (cnt_reg == `SMP_PREAMBLE_BITS) ? cnt_reg : cnt_reg + 6'd1;
            end else begin
              if (cnt_reg == `SMP_PREAMBLE_BITS) begin
                state_reg <= MD_HEADER;
              end
              cnt_reg <= '0;
            end
          end
          MD_HEADER: begin
            shift_reg <= {shift_reg[14:0], mdio_i};
            cnt_reg <= cnt_reg + 6'd1;
            if (cnt_reg == `SMP_HDR_LAST) begin
              cnt_reg <= '0;
              state_reg <= hdr_ok ? MD_TURN : MD_PREAMBLE;
              is_read_reg <= hdr[11];
              mgmt.chan <= hdr[5];
              mgmt.regad <= hdr[4:0];
              mgmt.rd_strobe <= hdr_ok & hdr[11];
            end
          end
          MD_TURN: begin
            cnt_reg <= cnt_reg + 6'd1;
            if (is_read_reg) begin
              mdio_oe <= 1'b1; // Second turnaround bit driven low
              mdio_o <= 1'b0;
              cnt_reg <= '0;
              state_reg <= MD_RDATA;
            end else if (cnt_reg == 6'd1) begin
              cnt_reg <= '0;
              state_reg <= MD_WDATA;
            end
          end
          MD_RDATA: begin
            cnt_reg <= cnt_reg + 6'd1;
            if (cnt_reg == `SMP_DATA_BITS) begin
              mdio_oe <= 1'b0;
              cnt_reg <= '0;
              state_reg <= MD_PREAMBLE;
            end else begin
              mdio_o <= shift_reg[15];
              shift_reg <= {shift_reg[14:0], 1'b0};
            end
          end
          MD_WDATA: begin
            shift_reg <= {shift_reg[14:0], mdio_i};
            cnt_reg <= cnt_reg + 6'd1;
            if (cnt_reg == `SMP_DATA_LAST) begin
              mgmt.wdata <= {shift_reg[14:0], mdio_i};
              mgmt.wr_strobe <= 1'b1;
              cnt_reg <= '0;
              state_reg <= MD_PREAMBLE;
            end
          end
        endcase
      end
    end
  end

  turn_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
    rise && state_reg == MD_TURN && is_read_reg |=> mdio_oe && !mdio_o)
    else $error("read turnaround not driven low");
endmodule // smp_mdio_slave

// ===== rtl/smp_chan_status.sv
`timescale 1ns/1ps
`include "smp_defines.svh"
module smp_chan_status (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire smp_pkg::smp_word_t raw,
  output smp_pkg::smp_word_t health
);
  import smp_pkg::*;
  localparam smp_word_t LOW = `SMP_HEALTH_LATCH_LOW;
  localparam smp_word_t HIGH = `SMP_HEALTH_LATCH_HIGH;

  // Good flags latch low, fault flags latch high, read reloads live value
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      health <= '0;
    end else if (clear) begin
      health <= raw & (LOW | HIGH);
    end else begin
      health <= (health & raw & LOW) | ((health | raw) & HIGH);
    end
  end

  clear_reload_a: assert property (@(posedge clk) disable iff (!reset_n)
    clear |=> health == ($past(raw) & (LOW | HIGH)))
    else $error("health not reloaded on read");
  fault_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
    (raw & HIGH) != 16'h0000 |=> (health & $past(raw) & HIGH) == ($past(raw) & HIGH))
    else $error("fault event lost");
  good_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
    !raw[3] && !raw[2] |=> !health[3] && !health[2])
    else $error("lane good flag not latched low");
endmodule // smp_chan_status

// ===== tb/smp_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Management host model
// ----------------------------------------
module smp_host_model (
  input wire logic clk,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  output logic mdc,
  output logic mdio_i
);
  import smp_pkg::*;
  logic host_oe = 1'b0;
  logic host_d = 1'b1;
  // Shared data line with pull-up: released reads one
  assign mdio_i = mdio_oe ? mdio_o : (host_oe ? host_d : 1'b1);
  initial mdc = 1'b0;
  // One bit: low half, then rise, line sampled at the rise
  task automatic bit_cycle(input logic oe, input logic d, output logic s);
    host_oe <= oe;
    host_d <= d;
    repeat (2) @(posedge clk);
    s = mdio_i;
    mdc <= 1'b1;
    repeat (2) @(posedge clk);
    mdc <= 1'b0;
  endtask
  // Whole frame with its own preamble; clock stands low between frames
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                       input smp_word_t wd, output smp_word_t q);
    logic [63:0] vec;
    logic s;
    vec = {32'hFFFFFFFF, 2'h1, rd ? 2'h2 : 2'h1, phy, ra, 2'h2, wd};
    q = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      bit_cycle(!(rd && i >= 46), vec[63 - i], s);
      if (i >= 48) q = {q[14:0], s};
    end
    host_oe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule // smp_host_model

// ===== tb/smp_provisioning_tb.sv
`timescale 1ns/1ps
`include "smp_defines.svh"
module smp_provisioning_tb;
  import smp_pkg::*;
  logic clk, reset_n, mdc, mdio_i, mdio_o, mdio_oe, cra;
  logic pd_a = 1'b1, pd_b = 1'b1, pat = 1'b0, rs_a = 1'b0, rs_b = 1'b0;
  logic [4:0] pa = 5'h04;
  smp_word_t raw_a = 16'h0000, raw_b = 16'h0000, raw_q;
  logic [1:0] pgr, rxd, txs, rxp, txp, refs, fre, fpo, lpr;
  logic [1:0][3:0] fpm, spm, lane;
  logic [1:0][1:0] frr, ftr, sir, sor;
  int fail_count = 0, num_checks = 0, pr_cnt = 0;
  // ----------------------------------------
  // Clock, partner and device
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) pr_cnt <= pr_cnt + lpr[0] + lpr[1];
  smp_host_model host_u (.clk(clk), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_i(mdio_i));
  smp_provisioning dut_u (.clk(clk), .reset_n(reset_n), .mdc(mdc), .mdio_i(mdio_i),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .port_address(pa), .chan_a_powerdown_n(pd_a),
    .chan_b_powerdown_n(pd_b), .pattern_gen_enable_pin(pat), .chan_a_refclk_pin_select(rs_a),
    .chan_b_refclk_pin_select(rs_b), .chan_a_health_raw(raw_a), .chan_b_health_raw(raw_b),
    .core_reset_active(cra), .pattern_gen_run(pgr), .rx_deser_ratio_select(rxd),
    .tx_ser_ratio_select(txs), .rx_lane_pass_through(rxp), .tx_lane_pass_through(txp),
    .ref_input_select(refs), .fast_pll_multiplier(fpm), .fast_rx_rate(frr),
    .fast_tx_rate(ftr), .fast_receive_enable(fre), .fast_peaking_off(fpo),
    .slow_pll_multiplier(spm), .slow_input_rate(sir), .slow_output_rate(sor),
    .lane_enable(lane), .lane_path_reset(lpr));
  // ----------------------------------------
  // Compare and bus tasks
  // ----------------------------------------
  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic c, input logic [4:0] ra, input smp_word_t d);
    smp_word_t q;
    host_u.frame(1'b0, {pa[4:1], c}, ra, d, q);
  endtask
  task automatic chk_reg(input logic c, input logic [4:0] ra, input smp_word_t exp);
    smp_word_t q;
    host_u.frame(1'b1, {pa[4:1], c}, ra, 16'h0000, q);
    chk_pin(q, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk_pin(lane, {`SMP_LANES_DUAL, `SMP_LANES_DUAL});
    chk_pin(refs, 16'h0000);
    chk_reg(1'b0, 5'h02, `SMP_RST_FAST_CTL1);
    chk_reg(1'b1, 5'h07, `SMP_RST_SLOW_CTL2);
    chk_reg(1'b0, 5'h0A, 16'h0000);
    pat <= 1'b1;
    repeat (2) @(posedge clk);
    chk_pin(pgr, 16'h0003);
    pat <= 1'b0;
  endtask
  task automatic t_chan_sel;
    wr(1'b0, 5'h02, 16'h811D);
    chk_reg(1'b1, 5'h02, `SMP_RST_FAST_CTL1);
    chk_pin(fpm, 16'h005D);
    host_u.frame(1'b0, 5'h18, 5'h02, 16'h0000, raw_q);
    chk_reg(1'b0, 5'h02, 16'h811D);
    wr(1'b1, 5'h02, 16'h8119);
    chk_pin(fpm, 16'h009D);
  endtask
  task automatic t_two_lane;
    wr(1'b0, 5'h00, 16'h0800);
    chk_reg(1'b1, 5'h00, 16'h0800);
    wr(1'b0, 5'h01, 16'h0002);
    chk_pin({refs, rxd, txs}, 16'h0030);
    wr(1'b0, 5'h02, 16'h811D);
    wr(1'b1, 5'h09, 16'h0B00);
    wr(1'b0, 5'h06, 16'hF119);
    wr(1'b0, 5'h07, 16'hDC04);
    chk_pin({fpm, frr, ftr}, 16'hDD00);
    chk_pin({spm, sir, sor}, 16'h9900);
    chk_pin(fpo, 16'h0003);
    wr(1'b0, 5'h03, 16'hA440);
    chk_pin(fre, 16'h0000);
    wr(1'b1, 5'h03, 16'hA444);
    chk_pin(fre, 16'h0003);
    wr(1'b0, 5'h0E, 16'h0008);
    chk_pin(16'(pr_cnt), 16'h0002);
  endtask
  task automatic t_health;
    raw_a <= 16'h5C0F;
    raw_b <= 16'h5C0F;
    chk_reg(1'b0, 5'h0F, 16'h0000);
    chk_reg(1'b0, 5'h0F, 16'h5C0F);
    chk_reg(1'b1, 5'h0F, 16'h0000);
    raw_a <= 16'h7CFE;
    raw_b <= 16'h7CFE;
    repeat (2) @(posedge clk);
    raw_a <= 16'h5C0F;
    raw_b <= 16'h5C0F;
    chk_reg(1'b0, 5'h0F, 16'h7CFE);
    chk_reg(1'b0, 5'h0F, 16'h5C0F);
    chk_reg(1'b1, 5'h0F, 16'h7CFE);
    pd_b <= 1'b0;
    chk_reg(1'b1, 5'h0F, 16'h0000);
    pd_b <= 1'b1;
  endtask
  task automatic t_one_lane;
    wr(1'b0, 5'h01, 16'h3000);
    wr(1'b0, 5'h03, 16'hA545);
    chk_pin({rxp, txp}, 16'h000F);
    chk_pin(lane, {`SMP_LANES_SINGLE, `SMP_LANES_SINGLE});
    chk_pin({frr, ftr}, 16'h0055);
  endtask
  task automatic t_soft_rst;
    wr(1'b0, 5'h01, 16'h0300);
    chk_pin({rxd, txs, lane}, 16'h0FFF);
    repeat (401) @(posedge clk);
    chk_pin(cra, 16'h0000);
    wr(1'b0, 5'h00, 16'h8000);
    chk_pin(cra, 16'h0001);
    chk_pin(lane, 16'h0033);
    chk_reg(1'b0, 5'h00, 16'h0000);
    chk_reg(1'b1, 5'h03, `SMP_RST_FAST_CTL2);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_chan_sel();
    t_two_lane();
    t_health();
    t_one_lane();
    t_soft_rst();
    end_sim();
  end
  initial begin
    #1000000;
    fail_count++;
    end_sim();
  end
endmodule // smp_provisioning_tb
